// *** acp_defs.svh ***
// constants for the serial command and address pointer block
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH

`define ACP_DEV_ID 2'h1
`define ACP_CMD_LAST 6'h07
`define ACP_FIRST_WRITABLE 5'h08
`define ACP_LOCK_KEY 8'ha5
`define ACP_LOCK_EXEMPT 5'h1f
`define ACP_ADDR_FIRST 5'h00
`define ACP_ADDR_LAST 5'h1f
`define ACP_DATA_LAST 5'h07
`define ACP_GROUP_MASK 5'h18
`define ACP_GROUP_LOW 5'h07
`define ACP_DEFINED_MASK 32'he00f_ff01

`define ACP_LOOP_STATIC 2'h0
`define ACP_LOOP_GROUPS 2'h1
`define ACP_LOOP_TYPES 2'h2
`define ACP_LOOP_FULL 2'h3
`define ACP_READ_LOOP_RESET 2'h2
`define ACP_WRITE_LOOP_RESET 1'h1

`define ACP_FMT_16 2'h0
`define ACP_FMT_24 2'h1
`define ACP_TOP_16 5'h0f
`define ACP_TOP_24 5'h17
`define ACP_TOP_32 5'h1f

`define ACP_CS_IDLE 1'h1
`define ACP_SCK_IDLE 1'h0
`define ACP_READY_IDLE 1'h1

`endif

// *** acp_pkg.sv ***
// types shared by the serial command and address pointer block
package acp_pkg;

    typedef enum logic [2:0] {
        ACP_IDLE,
        ACP_CMD,
        ACP_READ,
        ACP_WRITE,
        ACP_STALL,
        ACP_IGNORE
    } acp_state_type;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic sdi;
        logic ready_n;
    } acp_link_type;

    typedef struct packed {
        logic [1:0] dev_addr;
        logic [4:0] reg_addr;
        logic read;
    } acp_cmd_type;

endpackage

// *** acp_pin_sync.sv ***
// two-stage synchroniser and edge finder for the serial link pins
`timescale 1ns/1ps
`include "acp_defs.svh"

module acp_pin_sync
(
    input wire logic clk,
    input wire logic reset,
    input acp_pkg::acp_link_type pins,
    output acp_pkg::acp_link_type level,
    output logic sck_rise,
    output logic sck_fall,
    output logic ready_fall
);

    localparam acp_pkg::acp_link_type IDLE_LINK = '{cs_n: `ACP_CS_IDLE, sck: `ACP_SCK_IDLE,
                                                   sdi: 1'h0, ready_n: `ACP_READY_IDLE};

    acp_pkg::acp_link_type meta_reg;
    acp_pkg::acp_link_type sync_reg;
    acp_pkg::acp_link_type prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // meta stage feeds the sync stage only; edges come from later stages
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_reg <= IDLE_LINK;
            sync_reg <= IDLE_LINK;
            prev_reg <= IDLE_LINK;
        end
        else
        begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign sck_rise = sync_reg.sck & ~prev_reg.sck;
    assign sck_fall = ~sync_reg.sck & prev_reg.sck;
    assign ready_fall = ~sync_reg.ready_n & prev_reg.ready_n;

endmodule

// *** acp_spi_core.sv ***
// command decode, register streaming and address pointer of the serial port
// Function
// - command byte: device, register address, direction
// - output high impedance during command byte
// - answer only matching device address, default 01
// - read streams registers with auto-increment
// - output changes on falling clock edge
// - write samples rising edges, auto-increments
// - output high impedance during writes
// - non-writable address: no change, pointer holds
// - one command byte per chip select
// - pointer wraps to set start
// - pointer skips undefined addresses
// - read loop selector picks read set
// - write loop selector picks write set
// - continuous read ignores input data
// - mode 0,0 output refreshed at ready
// - mode 1,1 output holds last bit
// - lock code gates all but 0x1f
// - chip select rise returns to idle
// - word length 16, 24 or 32
`timescale 1ns/1ps
`include "acp_defs.svh"

module acp_spi_core
#(
    parameter logic [1:0] DEVICE_ID = `ACP_DEV_ID,
    parameter logic [31:0] DEFINED_MASK = `ACP_DEFINED_MASK
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic sdi_pin,
    input wire logic conversion_ready_strobe_n,
    input wire logic [1:0] read_loop,
    input wire logic write_loop,
    input wire logic [1:0] data_format,
    input wire logic [7:0] lock_code,
    input wire logic [31:0] reg_rd_data,
    output logic sdo_out,
    output logic sdo_oe_n,
    output logic [4:0] reg_addr,
    output logic [31:0] reg_wr_data,
    output logic reg_wr_strobe,
    output logic write_stalled
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [4:0] word_top(input logic [1:0] fmt);
        logic [4:0] top;
        top = `ACP_TOP_32;
        if (fmt == `ACP_FMT_16)
            top = `ACP_TOP_16;
        else if (fmt == `ACP_FMT_24)
            top = `ACP_TOP_24;
        return top;
    endfunction

    // set bounds by loop code; static keeps the pointer where it is
    function automatic logic [9:0] set_bounds(input logic [4:0] a, input logic [1:0] sel);
        logic [9:0] b;
        b = {a, a};
        case (sel)
            `ACP_LOOP_GROUPS: b = {a & `ACP_GROUP_MASK, (a & `ACP_GROUP_MASK) | `ACP_GROUP_LOW};
            `ACP_LOOP_TYPES: b = (a <= `ACP_DATA_LAST) ? {`ACP_ADDR_FIRST, `ACP_DATA_LAST}
                                                        : {`ACP_FIRST_WRITABLE, `ACP_ADDR_LAST};
            `ACP_LOOP_FULL: b = {`ACP_ADDR_FIRST, `ACP_ADDR_LAST};
            default: b = {a, a};
        endcase
        return b;
    endfunction

    function automatic logic [4:0] next_addr(input logic [4:0] a, input logic [1:0] sel);
        logic [9:0] b;
        logic [4:0] c;
        logic [4:0] n;
        logic found;
        b = set_bounds(a, sel);
        c = a;
        n = a;
        found = 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            c = (c == b[4:0]) ? b[9:5] : c + 5'h01;
            if (!found && DEFINED_MASK[c])
            begin
                n = c;
                found = 1'b1;
            end
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin sampling

    acp_pkg::acp_link_type pins;
    acp_pkg::acp_link_type link;
    logic sck_rise;
    logic sck_fall;
    logic ready_fall;

    assign pins = '{cs_n: cs_n_pin, sck: sck_pin, sdi: sdi_pin, ready_n: conversion_ready_strobe_n};

    acp_pin_sync u_sync
    (
        .clk(clk),
        .reset(reset),
        .pins(pins),
        .level(link),
        .sck_rise(sck_rise),
        .sck_fall(sck_fall),
        .ready_fall(ready_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state and decode

    acp_pkg::acp_state_type state_reg;
    acp_pkg::acp_state_type state_next;
    logic [5:0] bit_cnt_reg;
    logic [5:0] bit_cnt_next;
    logic [6:0] cmd_shift_reg;
    logic [4:0] ptr_reg;
    logic [4:0] ptr_next;
    logic [31:0] wr_shift_reg;
    logic [31:0] rd_word_reg;
    logic [4:0] rd_idx_reg;
    logic rd_pending_reg;
    logic rd_fresh_reg;
    logic sdo_on_reg;
    logic sdo_reg;
    logic wr_strobe_reg;
    logic [31:0] wr_data_reg;
    logic stalled_reg;

    acp_pkg::acp_cmd_type cmd_word;
    wire [4:0] top = word_top(data_format);
    wire [5:0] top_wide = {1'b0, top};
    // eighth rising edge completes the command byte
    wire cmd_done = (state_reg == acp_pkg::ACP_CMD) && sck_rise && (bit_cnt_reg == `ACP_CMD_LAST);
    assign cmd_word = {cmd_shift_reg, link.sdi};
    // only our own device address is answered
    wire id_match = (cmd_word.dev_addr == DEVICE_ID);
    wire in_read = (state_reg == acp_pkg::ACP_READ);
    wire in_write = (state_reg == acp_pkg::ACP_WRITE);
    // word length follows the format setting
    wire wr_word_done = in_write && sck_rise && (bit_cnt_reg == top_wide);
    wire [31:0] wr_word = {wr_shift_reg[30:0], link.sdi};
    // lock key other than the password protects all but the lock register
    wire unlocked = (lock_code == `ACP_LOCK_KEY) || (ptr_reg == `ACP_LOCK_EXEMPT);
    // read-only and undefined addresses are not writable
    wire writable = (ptr_reg >= `ACP_FIRST_WRITABLE) && DEFINED_MASK[ptr_reg] && unlocked;
    wire rd_load = in_read && sck_fall && rd_pending_reg;
    wire rd_last_bit = in_read && sck_fall && !rd_pending_reg && (rd_idx_reg == 5'h00);
    // ready edge with clock idle low replaces the waiting top bit
    wire rd_refresh = in_read && ready_fall && rd_fresh_reg && !link.sck;
    // read set from the read loop code
    wire [4:0] rd_next_ptr = next_addr(ptr_reg, read_loop);
    // write set from the write loop bit, mapped onto static or types
    wire [1:0] wr_sel = write_loop ? `ACP_LOOP_TYPES : `ACP_LOOP_STATIC;
    wire [4:0] wr_next_ptr = next_addr(ptr_reg, wr_sel);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            acp_pkg::ACP_IDLE:
                if (!link.cs_n)
                    state_next = acp_pkg::ACP_CMD;
            acp_pkg::ACP_CMD:
                if (cmd_done)
                begin
                    // foreign commands are dropped until deselect
                    if (!id_match)
                        state_next = acp_pkg::ACP_IGNORE;
                    else if (cmd_word.read)
                        state_next = acp_pkg::ACP_READ;
                    else
                        state_next = acp_pkg::ACP_WRITE;
                end
            acp_pkg::ACP_WRITE:
                // stall on a protected address until the host restarts
                if (wr_word_done && !writable)
                    state_next = acp_pkg::ACP_STALL;
            default:
                state_next = state_reg;
        endcase
        // deselect aborts whatever was going on
        if (link.cs_n)
            state_next = acp_pkg::ACP_IDLE;
    end

    always_comb
    begin
        bit_cnt_next = bit_cnt_reg;
        if (cmd_done || wr_word_done || state_reg == acp_pkg::ACP_IDLE)
            bit_cnt_next = 6'h00;
        else if (sck_rise && (state_reg == acp_pkg::ACP_CMD || in_write))
            bit_cnt_next = bit_cnt_reg + 6'h01;
    end

    always_comb
    begin
        ptr_next = ptr_reg;
        // the single command byte seeds the pointer
        if (cmd_done)
            ptr_next = cmd_word.reg_addr;
        // next register once the current word is out
        else if (rd_last_bit)
            ptr_next = rd_next_ptr;
        // advance only after a stored word
        else if (wr_word_done && writable)
            ptr_next = wr_next_ptr;
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= acp_pkg::ACP_IDLE;
            bit_cnt_reg <= 6'h00;
            ptr_reg <= `ACP_ADDR_FIRST;
            stalled_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            ptr_reg <= ptr_next;
            stalled_reg <= (state_next == acp_pkg::ACP_STALL);
        end
    end

    // the first byte is always shifted as a command
    always_ff @(posedge clk)
    begin
        if (reset)
            cmd_shift_reg <= 7'h00;
        else if (state_reg == acp_pkg::ACP_CMD && sck_rise)
            cmd_shift_reg <= {cmd_shift_reg[5:0], link.sdi};
    end

    ////////////////////////////////////////////////////////////////////////////
    // write path

    // input bits are taken on rising clock edges
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_shift_reg <= 32'h0000_0000;
            wr_strobe_reg <= 1'b0;
            wr_data_reg <= 32'h0000_0000;
        end
        else
        begin
            if (in_write && sck_rise)
                wr_shift_reg <= wr_word;
            wr_strobe_reg <= wr_word_done && writable && !link.cs_n;
            if (wr_word_done && writable)
                wr_data_reg <= wr_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path
    // input data is never looked at here, so read streams ignore it

    always_ff @(posedge clk)
    begin
        if (reset || !in_read)
        begin
            rd_word_reg <= 32'h0000_0000;
            rd_idx_reg <= 5'h00;
            rd_pending_reg <= 1'b1;
            rd_fresh_reg <= 1'b0;
        end
        // next word loads on a fall, or a new conversion result replaces the waiting word
        else if (rd_load || rd_refresh)
        begin
            rd_word_reg <= reg_rd_data;
            rd_idx_reg <= top - 5'h01;
            rd_pending_reg <= 1'b0;
            rd_fresh_reg <= 1'b1;
        end
        else if (in_read && sck_fall)
        begin
            rd_fresh_reg <= 1'b0;
            rd_idx_reg <= rd_idx_reg - 5'h01;
            // after the last bit no edge follows in idle-high, so it holds
            if (rd_idx_reg == 5'h00)
                rd_pending_reg <= 1'b1;
        end
    end

    // pointer moves on the fall of the last bit, a bit period before the next fall, so read data has settled
    always_ff @(posedge clk)
    begin
        if (reset || !in_read)
        begin
            sdo_reg <= 1'b0;
            sdo_on_reg <= 1'b0;
        end
        // bits change on falling edges only, refresh aside
        else if (rd_load || rd_refresh)
        begin
            sdo_reg <= reg_rd_data[top];
            sdo_on_reg <= 1'b1;
        end
        else if (sck_fall)
            sdo_reg <= rd_word_reg[rd_idx_reg];
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // released during command, released during writes
    always_ff @(posedge clk)
    begin
        if (reset)
            sdo_oe_n <= 1'b1;
        else
            sdo_oe_n <= !(in_read && !link.cs_n && (sdo_on_reg || rd_load || rd_refresh));
    end

    assign sdo_out = sdo_reg;
    assign reg_addr = ptr_reg;
    assign reg_wr_data = wr_data_reg;
    assign reg_wr_strobe = wr_strobe_reg;
    assign write_stalled = stalled_reg;

endmodule

// *** acp_spi_core_properties.sv ***
// concurrent checks on the ports of the serial command block
`timescale 1ns/1ps
module acp_spi_core_properties
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic sdi_pin,
    input wire logic conversion_ready_strobe_n,
    input wire logic [1:0] read_loop,
    input wire logic write_loop,
    input wire logic [1:0] data_format,
    input wire logic [7:0] lock_code,
    input wire logic [31:0] reg_rd_data,
    input wire logic sdo_out,
    input wire logic sdo_oe_n,
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wr_data,
    input wire logic reg_wr_strobe,
    input wire logic write_stalled
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////
    // five samples cover the synchroniser and idle return delay
    property p_idle_hiz;
        cs_n_pin [*5] |-> sdo_oe_n;
    endproperty
    a_idle_hiz: assert property (p_idle_hiz) else $error("output driven while deselected");
    property p_wr_hiz;
        reg_wr_strobe |-> sdo_oe_n;
    endproperty
    a_wr_hiz: assert property (p_wr_hiz) else $error("output driven during write");
    property p_strobe_pulse;
        $rose(reg_wr_strobe) |=> !reg_wr_strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("write strobe longer than one cycle");
    // the target address is the pointer one cycle before the strobe
    property p_wr_writable;
        reg_wr_strobe |-> $past(reg_addr) >= 5'h08;
    endproperty
    a_wr_writable: assert property (p_wr_writable) else $error("write to read-only address");
    property p_wr_lock;
        reg_wr_strobe && $past(lock_code) != 8'ha5 |-> $past(reg_addr) == 5'h1f;
    endproperty
    a_wr_lock: assert property (p_wr_lock) else $error("write while locked");
    property p_stall_quiet;
        write_stalled |-> !reg_wr_strobe;
    endproperty
    a_stall_quiet: assert property (p_stall_quiet) else $error("write strobe while stalled");
    property p_stall_hold;
        write_stalled && $past(write_stalled) |-> $stable(reg_addr);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("pointer moved while stalled");
    // output bit lands three cycles after the falling clock, so the pin is low two samples back
    property p_sdo_fall;
        $changed(sdo_out) && !sdo_oe_n && !cs_n_pin && !$past(cs_n_pin, 4) |-> !$past(sck_pin, 2);
    endproperty
    a_sdo_fall: assert property (p_sdo_fall) else $error("output changed outside falling clock");
    property p_wr_static;
        reg_wr_strobe && !write_loop |-> reg_addr == $past(reg_addr);
    endproperty
    a_wr_static: assert property (p_wr_static) else $error("pointer moved in static write");
endmodule
////////////////////////////////////////////////////////////////
bind acp_spi_core acp_spi_core_properties u_acp_spi_core_properties
(
    .clk(clk), .reset(reset), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .sdi_pin(sdi_pin),
    .conversion_ready_strobe_n(conversion_ready_strobe_n), .read_loop(read_loop), .write_loop(write_loop),
    .data_format(data_format), .lock_code(lock_code), .reg_rd_data(reg_rd_data), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_strobe(reg_wr_strobe),
    .write_stalled(write_stalled)
);

// *** acp_host.sv ***
// host side serial master model driving the link pins
`timescale 1ns/1ps
module acp_host
(
    input wire logic clk,
    input wire logic sdo_out,
    input wire logic sdo_oe_n,
    output logic cs_n,
    output logic sck,
    output logic sdi
);
    logic cpol = 1'h0;
    logic oe_low = 1'h0;
    initial
    begin
        cs_n = 1'h1;
        sck = 1'h0;
        sdi = 1'h0;
    end
    ////////////////////////////////////////////////////////////////
    // command first
    task automatic start(input logic [7:0] cmd);
        logic [31:0] rx;
        @(posedge clk) sck <= cpol;
        repeat (4) @(posedge clk);
        cs_n <= 1'h0;
        repeat (4) @(posedge clk);
        oe_low = 1'h0;
        xfer({24'h0, cmd}, 8, rx);
    endtask
    // msb first, data on rising clock
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        // callers return on a clock edge, so each bit spans exactly eight clocks
        for (int i = n - 1; i >= 0; i--)
        begin
            sck <= 1'h0;
            sdi <= tx[i];
            repeat (4) @(posedge clk);
            sck <= 1'h1;
            repeat (4) @(posedge clk);
            // a released output reads inverted, so a late enable shows as a wrong bit
            rx = {rx[30:0], sdo_oe_n ? ~sdo_out : sdo_out};
            oe_low = oe_low | !sdo_oe_n;
        end
    endtask
    // clock rests at its mode level after the last word and between frames
    task automatic idle();
        @(posedge clk) sck <= cpol;
        repeat (6) @(posedge clk);
    endtask
    // released data line flips so a stale level is never mistaken for data
    task automatic stop();
        idle();
        cs_n <= 1'h1;
        sdi <= ~sdi;
        repeat (8) @(posedge clk);
    endtask
endmodule

// *** acp_spi_core_test.sv ***
// self-checking bench for the serial command and pointer block
`timescale 1ns/1ps
`include "acp_defs.svh"
module acp_spi_core_test;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic ready_n = 1'h1;
    logic [1:0] read_loop = 2'h2;
    logic write_loop = 1'h1;
    logic [1:0] data_format = 2'h0;
    logic [7:0] lock_code = 8'ha5;
    logic gen = 1'h0;
    logic [31:0] mask = `ACP_DEFINED_MASK;
    logic cs_n, sck, sdi, sdo_out, sdo_oe_n, reg_wr_strobe, write_stalled;
    logic [4:0] reg_addr, prev_addr;
    logic [31:0] reg_wr_data, rx, reg_rd_data;
    logic [4:0] wr_addr[$];
    logic [31:0] wr_data[$];
    int n_mismatch = 0;
    int n_tests = 0;
    function automatic logic [31:0] word(input logic [4:0] a, input int n);
        logic [31:0] w;
        w = {~a, 3'h5, a, 3'h2, gen, a, 2'h1, ~a, ~gen, a[0], ~a[0]};
        return (n == 32) ? w : w & ((32'h1 << n) - 32'h1);
    endfunction
    function automatic logic [4:0] nxt(input logic [4:0] a, input logic [1:0] sel);
        logic [4:0] lo;
        logic [4:0] hi;
        logic [4:0] b;
        lo = (sel == 2'h1) ? {a[4:3], 3'h0} : (sel == 2'h2 && a > 5'h07) ? 5'h08 : 5'h00;
        hi = (sel == 2'h1) ? {a[4:3], 3'h7} : (sel == 2'h2 && a < 5'h08) ? 5'h07 : 5'h1f;
        b = a;
        if (sel != 2'h0)
            do b = (b == hi) ? lo : b + 5'h01; while (!mask[b]);
        return b;
    endfunction
    // always_comb also follows gen, which the function reads without an argument
    always_comb reg_rd_data = word(reg_addr, 32);
    initial
    begin
        forever #50 clk = ~clk;
    end
    acp_host u_acp_host (.clk(clk), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .cs_n(cs_n), .sck(sck), .sdi(sdi));
    acp_spi_core u_acp_spi_core
    (
        .clk(clk), .reset(reset), .cs_n_pin(cs_n), .sck_pin(sck), .sdi_pin(sdi),
        .conversion_ready_strobe_n(ready_n), .read_loop(read_loop), .write_loop(write_loop),
        .data_format(data_format), .lock_code(lock_code), .reg_rd_data(reg_rd_data), .sdo_out(sdo_out),
        .sdo_oe_n(sdo_oe_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_strobe(reg_wr_strobe),
        .write_stalled(write_stalled)
    );
    ////////////////////////////////////////////////////////////////
    // pointer is already advanced while the strobe is high, so keep last cycle's;
    // sampled mid-cycle so outputs launched on the rising edge have settled
    always @(negedge clk)
    begin
        prev_addr <= reg_addr;
        if (reg_wr_strobe === 1'h1)
        begin
            wr_addr.push_back(prev_addr);
            wr_data.push_back(reg_wr_data);
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // format follows the loop selector so lengths 16 and 24 are read once and 32 twice
    task automatic read_run(input logic [1:0] sel, input logic [4:0] a0, input int words);
        logic [4:0] a;
        int n;
        a = a0;
        n = (sel == 2'h0) ? 16 : (sel == 2'h1) ? 24 : 32;
        @(posedge clk) read_loop <= sel;
        data_format <= sel;
        u_acp_host.start({`ACP_DEV_ID, a0, 1'h1});
        check("drive in command", u_acp_host.oe_low, 1'h0);
        repeat (words)
        begin
            u_acp_host.xfer(32'hffff_ffff, n, rx);
            check("read word", rx, word(a, n));
            a = nxt(a, sel);
        end
    endtask
    task automatic write_run(input logic [4:0] a0, input logic [15:0] d);
        u_acp_host.start({`ACP_DEV_ID, a0, 1'h0});
        u_acp_host.xfer({16'h0, d}, 16, rx);
        u_acp_host.xfer({16'h0, ~d}, 16, rx);
        check("drive in write", u_acp_host.oe_low, 1'h0);
    endtask
    task automatic expect_writes(input int n, input logic [4:0] a0, input logic [4:0] a1);
        check("write count", wr_addr.size(), n);
        if (n > 0 && wr_addr.size() > 0)
            check("first target", wr_addr[0], a0);
        if (n > 1 && wr_addr.size() > 1)
            check("second target", wr_addr[1], a1);
        wr_addr.delete();
        wr_data.delete();
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        repeat (6) @(posedge clk);
        for (int s = 0; s < 4; s++)
        begin
            read_run(s[1:0], 5'h13, 3);
            u_acp_host.stop();
        end
        check("writes during reads", wr_addr.size(), 0);
        $display("test read loops done");
        read_run(2'h0, 5'h08, 1);
        u_acp_host.idle();
        check("mode 0 tail", sdo_out, gen);
        @(posedge clk) gen <= ~gen;
        ready_n <= 1'h0;
        repeat (2) @(posedge clk);
        ready_n <= 1'h1;
        repeat (6) @(posedge clk);
        check("mode 0 refresh", sdo_out, gen);
        u_acp_host.stop();
        u_acp_host.cpol = 1'h1;
        read_run(2'h0, 5'h09, 1);
        u_acp_host.idle();
        check("mode 1 tail", sdo_out, 1'h0);
        u_acp_host.stop();
        u_acp_host.cpol = 1'h0;
        $display("test idle levels done");
        write_run(5'h13, 16'h1234);
        u_acp_host.stop();
        check("write data", {16'h0, wr_data[0][15:0]}, 32'h1234);
        expect_writes(2, 5'h13, 5'h1d);
        @(posedge clk) write_loop <= 1'h0;
        write_run(5'h09, 16'h00a5);
        u_acp_host.stop();
        expect_writes(2, 5'h09, 5'h09);
        write_run(5'h05, 16'h1111);
        check("stalled", write_stalled, 1'h1);
        check("held pointer", reg_addr, 5'h05);
        u_acp_host.stop();
        check("stall cleared", write_stalled, 1'h0);
        expect_writes(0, 5'h00, 5'h00);
        @(posedge clk) lock_code <= 8'h00;
        write_loop <= 1'h1;
        write_run(5'h12, 16'h2222);
        u_acp_host.stop();
        write_run(5'h1f, 16'h3333);
        u_acp_host.stop();
        expect_writes(1, 5'h1f, 5'h00);
        @(posedge clk) lock_code <= 8'ha5;
        $display("test writes done");
        u_acp_host.start({2'h2, 5'h13, 1'h1});
        u_acp_host.xfer(32'h0, 16, rx);
        check("foreign drive", u_acp_host.oe_low, 1'h0);
        u_acp_host.stop();
        u_acp_host.start({2'h0, 5'h12, 1'h0});
        u_acp_host.xfer(32'h0, 16, rx);
        u_acp_host.stop();
        expect_writes(0, 5'h00, 5'h00);
        $display("test foreign address done");
        complete_run();
    end
endmodule
